// *** hw/bmx_pkg.sv ***
package bmx_pkg;
  // Clock rate and stuck-bus timeout lengths
  localparam int CLK_MHZ = 100;
  localparam int TO_LONG_US = 30000;
  localparam int TO_MID_US = 15000;
  localparam int TO_SHORT_US = 7500;
  localparam int TO_LONG_CYC = TO_LONG_US * CLK_MHZ;
  localparam int TO_MID_CYC = TO_MID_US * CLK_MHZ;
  localparam int TO_SHORT_CYC = TO_SHORT_US * CLK_MHZ;

  // Register indices
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_CFG = 2'h2;
  localparam logic [1:0] REG_SWITCH = 2'h3;

  // Reset images and write mask of the writable registers, all-high fault pattern
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam logic [7:0] CTRL_WMASK = 8'hf0;
  localparam logic [7:0] CFG_RST = 8'h04;
  localparam logic [3:0] SW_RST = 4'h0;
  localparam logic [3:0] ALL_HIGH = 4'hf;

  // Field positions
  localparam int CT_ACC_UP = 7;
  localparam int CT_ACC_DN = 6;
  localparam int CT_GSTATE = 4;
  localparam int CFG_GMODE = 6;
  localparam int CFG_CONNREQ = 5;
  localparam int CFG_GPP = 3;
  localparam int CFG_TSEL = 0;

  // Stuck timeout select codes
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic [1:0] TSEL_LONG = 2'h1;
  localparam logic [1:0] TSEL_MID = 2'h2;

  // Bus addressing
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [1:0] ADR_HIGH = 2'h1;
  localparam logic [1:0] ADR_FLOAT = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_W = 19;

  typedef enum logic [2:0] {
    BMX_IDLE = 3'h0,
    BMX_ADDR = 3'h1,
    BMX_ACK = 3'h2,
    BMX_WR = 3'h3,
    BMX_RD = 3'h4,
    BMX_RACK = 3'h5,
    BMX_RNXT = 3'h6
  } bmx_state_t;
endpackage

// *** hw/bmx_status_ctrl.sv ***
`timescale 1ns/1ps
module bmx_status_ctrl #(
  parameter int T_LONG_CYC = bmx_pkg::TO_LONG_CYC,
  parameter int T_MID_CYC = bmx_pkg::TO_MID_CYC,
  parameter int T_SHORT_CYC = bmx_pkg::TO_SHORT_CYC,
  parameter int TCNT_W = 22,
  parameter logic [6:0] ADDR_BASE = 7'h40
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic upstream_serial_clock,
  input wire logic upstream_serial_data,
  output logic upstream_serial_data_out,
  output logic upstream_serial_data_oe_n,
  input wire logic enable,
  input wire logic [3:0] channel_fault_inputs,
  input wire logic [3:0] downstream_bus_high,
  input wire logic [5:0] slave_address_selects,
  input wire logic [1:0] aux_pins_in,
  output logic [1:0] aux_pins_out,
  output logic [1:0] aux_pins_oe_n,
  output logic fault_out,
  output logic fault_oe_n,
  output logic ready_out,
  output logic ready_oe_n,
  output logic accel_up_en,
  output logic accel_dn_en,
  output logic [3:0] switch_closed
);
  logic [bmx_pkg::SYNC_W-1:0] sync_m_q;
  logic [bmx_pkg::SYNC_W-1:0] sync_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_s;
  logic sda_s;
  logic en_s;
  logic [3:0] fault_s;
  logic [3:0] bus_high_s;
  logic [1:0] aux_s;
  logic [5:0] adr_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [6:0] own_addr;
  logic [4:0] adr_idx;
  logic alert_c;
  logic stuck_c;
  logic [TCNT_W-1:0] lim_c;
  logic [7:0] rdata_c;
  logic [7:0] nb_c;
  logic [3:0] req_c;

  bmx_pkg::bmx_state_t st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] ptr_q, ptr_d;
  logic idx_q, idx_d;
  logic rw_q, rw_d;
  logic ara_q, ara_d;
  logic oe_q, oe_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] cfg_q, cfg_d;
  logic [3:0] sw_q, sw_d;
  logic fail_q, fail_d;
  logic tlat_q, tlat_d;
  logic tlive_q, tlive_d;
  logic [TCNT_W-1:0] tcnt_q, tcnt_d;
  logic fault_oe_n_q, fault_oe_n_d;
  logic ready_oe_n_q, ready_oe_n_d;
  logic [1:0] aux_out_q, aux_out_d;
  logic [1:0] aux_oe_n_q, aux_oe_n_d;
  logic zero_q;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_m_q <= '1;
      sync_q <= '1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      zero_q <= 1'b0;
    end else begin
      sync_m_q <= {upstream_serial_clock, upstream_serial_data, enable,
                   channel_fault_inputs, downstream_bus_high, aux_pins_in,
                   slave_address_selects};
      sync_q <= sync_m_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      zero_q <= 1'b0;
    end
  end

  // Unpack synchronised inputs and find bus events
  assign {scl_s, sda_s, en_s, fault_s, bus_high_s, aux_s, adr_s} = sync_q;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Ternary value of one address select
  function automatic logic [4:0] tern(input logic [1:0] code);
    if (code == bmx_pkg::ADR_HIGH) begin
      tern = 5'h01;
    end else if (code == bmx_pkg::ADR_FLOAT) begin
      tern = 5'h02;
    end else begin
      tern = 5'h00;
    end
  endfunction

  // Own slave address from the three selects
  assign adr_idx = 5'(tern(adr_s[5:4]) * 5'h09 + tern(adr_s[3:2]) * 5'h03
                      + tern(adr_s[1:0]));
  assign own_addr = 7'(ADDR_BASE + {2'h0, adr_idx});

  // Fault summary and stuck-bus detect
  assign alert_c = (fault_s != bmx_pkg::ALL_HIGH) | tlat_q | fail_q;
  assign stuck_c = ~scl_s | ~sda_s;
  assign nb_c = {sh_q[6:0], sda_s};

  // Timeout length for the selected mode
  always_comb begin
    unique case (cfg_q[bmx_pkg::CFG_TSEL +: 2])
      bmx_pkg::TSEL_LONG: lim_c = TCNT_W'(T_LONG_CYC - 1);
      bmx_pkg::TSEL_MID: lim_c = TCNT_W'(T_MID_CYC - 1);
      default: lim_c = TCNT_W'(T_SHORT_CYC - 1);
    endcase
  end

  // Read data for the current register
  always_comb begin
    if (ara_q) begin
      rdata_c = {own_addr, 1'b0};
    end else begin
      unique case (ptr_q)
        bmx_pkg::REG_STATUS:
          rdata_c = {|sw_q, fault_s, ~fail_q, tlat_q, tlive_q};
        bmx_pkg::REG_CTRL: rdata_c = {ctrl_q[7:4], 2'h0, aux_s};
        bmx_pkg::REG_CFG: rdata_c = cfg_q;
        default: rdata_c = {sw_q, bus_high_s};
      endcase
    end
  end

  // Next state of the bus slave, registers and timeout
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    idx_d = idx_q;
    rw_d = rw_q;
    ara_d = ara_q;
    oe_d = oe_q;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    sw_d = sw_q;
    fail_d = fail_q;
    tlat_d = tlat_q;
    tlive_d = tlive_q;
    tcnt_d = tcnt_q;
    req_c = nb_c[7:4];
    if (start_c) begin
      st_d = bmx_pkg::BMX_ADDR;
      bit_d = 3'h0;
      oe_d = 1'b1;
    end else if (stop_c) begin
      st_d = bmx_pkg::BMX_IDLE;
      oe_d = 1'b1;
    end else begin
      unique case (st_q)
        bmx_pkg::BMX_IDLE: begin
          oe_d = 1'b1;
        end
        bmx_pkg::BMX_ADDR: begin
          if (scl_rise) begin
            sh_d = nb_c;
            bit_d = bit_q + 3'h1;
            if (bit_q == bmx_pkg::LAST_BIT) begin
              idx_d = 1'b1;
              if (nb_c[7:1] == own_addr) begin
                rw_d = nb_c[0];
                ara_d = 1'b0;
                st_d = bmx_pkg::BMX_ACK;
              end else if (nb_c[7:1] == bmx_pkg::ARA_ADDR && nb_c[0] && alert_c) begin
                rw_d = 1'b1;
                ara_d = 1'b1;
                st_d = bmx_pkg::BMX_ACK;
              end else begin
                st_d = bmx_pkg::BMX_IDLE;
              end
            end
          end
        end
        bmx_pkg::BMX_ACK: begin
          if (scl_fall) begin
            bit_d = 3'h0;
            if (oe_q) begin
              oe_d = 1'b0;
            end else if (rw_q) begin
              oe_d = rdata_c[7];
              sh_d = {rdata_c[6:0], 1'b0};
              ptr_d = ara_q ? ptr_q : ptr_q + 2'h1;
              st_d = bmx_pkg::BMX_RD;
            end else begin
              oe_d = 1'b1;
              st_d = bmx_pkg::BMX_WR;
            end
          end
        end
        bmx_pkg::BMX_WR: begin
          if (scl_rise) begin
            sh_d = nb_c;
            bit_d = bit_q + 3'h1;
            if (bit_q == bmx_pkg::LAST_BIT) begin
              st_d = bmx_pkg::BMX_ACK;
              if (idx_q) begin
                ptr_d = nb_c[1:0];
                idx_d = 1'b0;
              end else begin
                ptr_d = ptr_q + 2'h1;
                unique case (ptr_q)
                  bmx_pkg::REG_STATUS: begin
                    fail_d = 1'b0;
                    tlat_d = 1'b0;
                  end
                  bmx_pkg::REG_CTRL: ctrl_d = nb_c & bmx_pkg::CTRL_WMASK;
                  bmx_pkg::REG_CFG: cfg_d = nb_c;
                  default: begin
                    // Refuse closing onto a low channel unless forced
                    if (!cfg_q[bmx_pkg::CFG_CONNREQ]) begin
                      req_c = nb_c[7:4] & (sw_q | bus_high_s);
                      if (req_c != nb_c[7:4]) begin
                        fail_d = 1'b1;
                      end
                    end
                    sw_d = req_c;
                  end
                endcase
              end
            end
          end
        end
        bmx_pkg::BMX_RD: begin
          if (scl_fall) begin
            oe_d = sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
          end else if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == bmx_pkg::LAST_BIT) begin
              st_d = bmx_pkg::BMX_RACK;
            end
          end
        end
        bmx_pkg::BMX_RACK: begin
          if (scl_fall) begin
            oe_d = 1'b1;
          end else if (scl_rise) begin
            st_d = sda_s ? bmx_pkg::BMX_IDLE : bmx_pkg::BMX_RNXT;
          end
        end
        default: begin
          if (scl_fall) begin
            bit_d = 3'h0;
            oe_d = rdata_c[7];
            sh_d = {rdata_c[6:0], 1'b0};
            ptr_d = ara_q ? ptr_q : ptr_q + 2'h1;
            st_d = bmx_pkg::BMX_RD;
          end
        end
      endcase
    end
    // Stuck-low timeout; its set follows the clear so it wins
    if (!stuck_c) begin
      tcnt_d = '0;
      tlive_d = 1'b0;
    end else if (cfg_q[bmx_pkg::CFG_TSEL +: 2] != bmx_pkg::TSEL_OFF && (|sw_q || tlive_q)) begin
      if (tcnt_q >= lim_c) begin
        tlive_d = 1'b1;
        tlat_d = 1'b1;
        sw_d = bmx_pkg::SW_RST;
      end else begin
        tcnt_d = tcnt_q + 1'b1;
      end
    end
    // Disabled: bus ignored and registers held at default
    if (!en_s) begin
      st_d = bmx_pkg::BMX_IDLE;
      oe_d = 1'b1;
      ptr_d = bmx_pkg::REG_STATUS;
      ara_d = 1'b0;
      ctrl_d = bmx_pkg::CTRL_RST;
      cfg_d = bmx_pkg::CFG_RST;
      sw_d = bmx_pkg::SW_RST;
      fail_d = 1'b0;
      tlat_d = 1'b0;
      tlive_d = 1'b0;
      tcnt_d = '0;
    end
  end

  // Pin drivers for fault, ready and aux pins
  always_comb begin
    fault_oe_n_d = ~alert_c;
    ready_oe_n_d = |sw_d;
    for (int i = 0; i < 2; i++) begin
      if (ctrl_d[bmx_pkg::CT_GSTATE + i] == 1'b1 && cfg_d[bmx_pkg::CFG_GMODE + i]) begin
        aux_out_d[i] = 1'b1;
      end else begin
        aux_out_d[i] = cfg_d[bmx_pkg::CFG_GPP + i] & ctrl_d[bmx_pkg::CT_GSTATE + i];
      end
      if (cfg_d[bmx_pkg::CFG_GMODE + i]) begin
        aux_oe_n_d[i] = 1'b1;
      end else if (cfg_d[bmx_pkg::CFG_GPP + i]) begin
        aux_oe_n_d[i] = 1'b0;
      end else begin
        aux_oe_n_d[i] = ctrl_d[bmx_pkg::CT_GSTATE + i];
      end
    end
  end

  // State and register flip-flops
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= bmx_pkg::BMX_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= bmx_pkg::REG_STATUS;
      idx_q <= 1'b0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      oe_q <= 1'b1;
      ctrl_q <= bmx_pkg::CTRL_RST;
      cfg_q <= bmx_pkg::CFG_RST;
      sw_q <= bmx_pkg::SW_RST;
      fail_q <= 1'b0;
      tlat_q <= 1'b0;
      tlive_q <= 1'b0;
      tcnt_q <= '0;
      fault_oe_n_q <= 1'b1;
      ready_oe_n_q <= 1'b0;
      aux_out_q <= 2'h0;
      aux_oe_n_q <= 2'h3;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      ara_q <= ara_d;
      oe_q <= oe_d;
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      sw_q <= sw_d;
      fail_q <= fail_d;
      tlat_q <= tlat_d;
      tlive_q <= tlive_d;
      tcnt_q <= tcnt_d;
      fault_oe_n_q <= fault_oe_n_d;
      ready_oe_n_q <= ready_oe_n_d;
      aux_out_q <= aux_out_d;
      aux_oe_n_q <= aux_oe_n_d;
    end
  end

  // Outputs straight from flops
  assign upstream_serial_data_out = zero_q;
  assign upstream_serial_data_oe_n = oe_q;
  assign fault_out = zero_q;
  assign fault_oe_n = fault_oe_n_q;
  assign ready_out = zero_q;
  assign ready_oe_n = ready_oe_n_q;
  assign aux_pins_out = aux_out_q;
  assign aux_pins_oe_n = aux_oe_n_q;
  assign accel_up_en = ctrl_q[bmx_pkg::CT_ACC_UP];
  assign accel_dn_en = ctrl_q[bmx_pkg::CT_ACC_DN];
  assign switch_closed = sw_q;
endmodule

// *** sim/bmx_chk.sv ***
`timescale 1ns/1ps
module bmx_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic upstream_serial_clock,
  input wire logic upstream_serial_data_out,
  input wire logic upstream_serial_data_oe_n,
  input wire logic enable,
  input wire logic [3:0] channel_fault_inputs,
  input wire logic [1:0] aux_pins_oe_n,
  input wire logic fault_out,
  input wire logic fault_oe_n,
  input wire logic ready_out,
  input wire logic ready_oe_n,
  input wire logic accel_up_en,
  input wire logic accel_dn_en,
  input wire logic [3:0] switch_closed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Fault, ready and bus pins only ever pull low; outputs held under reset
  a_fault_in: assert property ((channel_fault_inputs != 4'hf)[*7] |-> !fault_oe_n)
    else $error("fault pin not pulled for low fault input");
  a_od_low: assert property (!fault_out && !ready_out && !upstream_serial_data_out)
    else $error("open drain pin driven high");
  a_ready_open: assert property ((switch_closed == 4'h0)[*2] |-> !ready_oe_n)
    else $error("ready released with nothing connected");
  a_ready_conn: assert property ((switch_closed != 4'h0)[*2] |-> ready_oe_n)
    else $error("ready pulled while connected");
  a_reset_vals: assert property (disable iff (1'b0) sys_rst |->
    !accel_up_en && !accel_dn_en && switch_closed == 4'h0 && aux_pins_oe_n == 2'h3)
    else $error("wrong value under reset");
  // Disabled interface returns to defaults and leaves the bus alone; data line moves only while the clock is low
  a_en_dflt: assert property (!enable[*6] |-> switch_closed == 4'h0 &&
    !accel_up_en && !accel_dn_en && aux_pins_oe_n == 2'h3)
    else $error("defaults not restored while disabled");
  a_en_sda: assert property (!enable[*6] |-> upstream_serial_data_oe_n)
    else $error("data line driven while disabled");
  a_sda_move: assert property ($changed(upstream_serial_data_oe_n) |-> !upstream_serial_clock)
    else $error("data line changed while clock high");
endmodule

bind bmx_status_ctrl bmx_chk u_chk (.sys_clk, .sys_rst, .upstream_serial_clock,
  .upstream_serial_data_out, .upstream_serial_data_oe_n, .enable, .channel_fault_inputs,
  .aux_pins_oe_n, .fault_out, .fault_oe_n, .ready_out, .ready_oe_n, .accel_up_en,
  .accel_dn_en, .switch_closed);

// *** sim/bmx_master.sv ***
`timescale 1ns/1ps
module bmx_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int Q = 40;
  // Bus idles released, clock standing high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while clock high
  task automatic start();
    #3;
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // One bit, data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Byte MSB first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r,
    output logic sack);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(mack, sack);
  endtask
  // Hold the clock low to make a stuck bus
  task automatic stuck(input int ns);
    scl = 1'b0;
    #ns scl = 1'b1;
  endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`define chk(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic enable = 1'b1;
  logic [3:0] channel_fault_inputs = 4'hf;
  logic [3:0] downstream_bus_high = 4'hf;
  logic [5:0] slave_address_selects = 6'h18;
  logic [1:0] aux_ext = 2'h3;
  logic [6:0] own = 7'h4f;
  logic m_low, upstream_serial_clock, upstream_serial_data;
  logic upstream_serial_data_out, upstream_serial_data_oe_n;
  logic [1:0] aux_pins_in, aux_pins_out, aux_pins_oe_n;
  logic fault_out, fault_oe_n, ready_out, ready_oe_n, accel_up_en, accel_dn_en;
  logic [3:0] switch_closed;
  int n_mismatch = 0;
  int tests_run = 0;

  always #5 sys_clk = ~sys_clk;
  // Wire levels with pull-ups
  assign upstream_serial_data = !(m_low || !upstream_serial_data_oe_n);
  assign aux_pins_in = (aux_pins_oe_n & aux_ext) | (~aux_pins_oe_n & aux_pins_out);

  bmx_master u_mst (.scl(upstream_serial_clock), .sda_low(m_low), .sda(upstream_serial_data));
  bmx_status_ctrl #(.T_LONG_CYC(300), .T_MID_CYC(150), .T_SHORT_CYC(75)) u_dut (.sys_clk,
    .sys_rst, .upstream_serial_clock, .upstream_serial_data, .upstream_serial_data_out,
    .upstream_serial_data_oe_n, .enable, .channel_fault_inputs, .downstream_bus_high,
    .slave_address_selects, .aux_pins_in, .aux_pins_out, .aux_pins_oe_n, .fault_out,
    .fault_oe_n, .ready_out, .ready_oe_n, .accel_up_en, .accel_dn_en, .switch_closed);

  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bus helpers
  task automatic put(input logic [7:0] b, input logic ack);
    logic [7:0] r;
    logic a;
    u_mst.xfer(b, 1'b1, r, a);
    `chk(a, ack)
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    u_mst.start();
    put({own, 1'b0}, 1'b0);
    put(idx, 1'b0);
    put(d, 1'b0);
    u_mst.stop();
    tick(4);
  endtask
  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic a;
    u_mst.start();
    put({own, 1'b0}, 1'b0);
    put(idx, 1'b0);
    u_mst.start();
    put({own, 1'b1}, 1'b0);
    u_mst.xfer(8'hff, 1'b1, r, a);
    `chk(r, exp)
    u_mst.stop();
    tick(4);
  endtask
  // Scenarios
  task automatic t_reset();
    `chk(aux_pins_oe_n, 2'h3)
    `chk(ready_oe_n, 1'b0)
    reg_rd(8'h01, 8'h33);
    reg_rd(8'h00, 8'h7c);
  endtask
  task automatic t_aux();
    reg_wr(8'h01, 8'hc0);
    `chk({accel_up_en, accel_dn_en, aux_pins_oe_n}, 4'hc)
    reg_rd(8'h01, 8'hc0);
    reg_wr(8'h02, 8'h1c);
    reg_wr(8'h01, 8'h30);
    `chk({aux_pins_oe_n, aux_pins_out}, 4'h3)
    reg_rd(8'h01, 8'h33);
    reg_wr(8'h02, 8'hc4);
    aux_ext = 2'h2;
    reg_rd(8'h01, 8'h32);
    aux_ext = 2'h3;
    reg_wr(8'h02, 8'h04);
  endtask
  task automatic t_conn();
    downstream_bus_high = 4'hb;
    reg_wr(8'h03, 8'hf0);
    `chk({switch_closed, fault_oe_n, ready_oe_n}, 6'h2d)
    reg_rd(8'h00, 8'hf8);
    reg_wr(8'h00, 8'h00);
    `chk({switch_closed, fault_oe_n}, 5'h17)
    reg_rd(8'h00, 8'hfc);
    reg_wr(8'h02, 8'h24);
    reg_wr(8'h03, 8'hf0);
    `chk(switch_closed, 4'hf)
    reg_wr(8'h03, 8'h00);
    reg_wr(8'h02, 8'h04);
    downstream_bus_high = 4'hf;
  endtask
  task automatic t_fault();
    logic [7:0] r;
    logic a;
    channel_fault_inputs = 4'h6;
    tick(8);
    `chk(fault_oe_n, 1'b0)
    reg_rd(8'h00, 8'h34);
    u_mst.start();
    put(8'h19, 1'b0);
    u_mst.xfer(8'hff, 1'b1, r, a);
    `chk(r, {own, 1'b0})
    u_mst.stop();
    channel_fault_inputs = 4'hf;
    tick(8);
    `chk(fault_oe_n, 1'b1)
  endtask
  task automatic t_stuck();
    reg_wr(8'h02, 8'h05);
    reg_wr(8'h03, 8'h80);
    `chk(switch_closed, 4'h8)
    fork
      u_mst.stuck(4000);
      tick(380);
    join
    `chk({switch_closed, fault_oe_n}, 5'h00)
    tick(8);
    reg_rd(8'h00, 8'h7e);
    reg_wr(8'h00, 8'h00);
    reg_rd(8'h00, 8'h7c);
    `chk(fault_oe_n, 1'b1)
    reg_wr(8'h02, 8'h04);
  endtask
  // Stuck clock held past the selected limit: switches stay until then, open after
  task automatic t_tmode(input logic [7:0] cfg, input int lim);
    reg_wr(8'h02, cfg);
    reg_wr(8'h03, 8'h80);
    fork
      u_mst.stuck(10 * lim + 400);
      begin
        tick(lim - 10);
        `chk({switch_closed, fault_oe_n}, 5'h11)
        tick(30);
        `chk({switch_closed, fault_oe_n}, 5'h00)
      end
    join
    tick(8);
    reg_wr(8'h00, 8'h00);
    reg_wr(8'h02, 8'h04);
    `chk(fault_oe_n, 1'b1)
  endtask
  task automatic t_enable();
    reg_wr(8'h01, 8'hc0);
    reg_wr(8'h03, 8'h10);
    enable = 1'b0;
    channel_fault_inputs = 4'he;
    tick(10);
    `chk({fault_oe_n, switch_closed, accel_up_en}, 6'h00)
    u_mst.start();
    put({own, 1'b0}, 1'b1);
    u_mst.stop();
    enable = 1'b1;
    channel_fault_inputs = 4'hf;
    tick(8);
    reg_rd(8'h01, 8'h33);
  endtask
  task automatic t_addr();
    logic [12:0] tab [3] = '{{6'h2a, 7'h5a}, {6'h3f, 7'h40}, {6'h15, 7'h4d}};
    foreach (tab[i]) begin
      slave_address_selects = tab[i][12:7];
      tick(6);
      u_mst.start();
      put({7'h4f, 1'b0}, 1'b1);
      u_mst.start();
      put({tab[i][6:0], 1'b0}, 1'b0);
      u_mst.stop();
    end
    slave_address_selects = 6'h18;
  endtask

  // Hang guard
  initial begin
    tick(90000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    #1 sys_rst = 1'b1; // Raised after time zero so the flops see a reset edge
    tick(5);
    sys_rst = 1'b0;
    tick(5);
    t_reset();
    t_aux();
    t_conn();
    t_fault();
    t_stuck();
    t_tmode(8'h06, 150);
    t_tmode(8'h07, 75);
    t_enable();
    t_addr();
    give_verdict();
  end
endmodule
